// *** verilog/fcc_fpu_slice.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_fpu_slice #(
    // arbitrary value, not tied to any part
    parameter logic [31:0] FIR_VALUE = 32'h0001_0000
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire fcc_pkg::fcc_axil_req_type axiReq,
    output var fcc_pkg::fcc_axil_rsp_type axiRsp
);
    import fcc_pkg::*;

    fcc_axil_rsp_type next_axiRsp;
    logic awFull, next_awFull, wFull, next_wFull, doWrite;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData, rdVal;
    logic [3:0] wStrb, next_wStrb;
    logic rdHit, wrHit;

    fcc_exec_state_type state, next_state;
    logic [31:0] instr, next_instr, srcLo, next_srcLo, srcHi, next_srcHi;
    logic [31:0] fp_control_status, next_fp_control_status, cfgWord, next_cfgWord, status, next_status;
    logic [31:0] resLo, next_resLo, resHi, next_resHi;

    logic isDbl, sgn, expAll, expZero, isNan, isInf, isZero, isDenorm;
    logic fracNz, huge, over, isLong, invalid, inexact;
    logic [51:0] frac;
    logic signed [12:0] ue;
    logic [63:0] mant, intMag, convVal, maxVal, minVal, defVal;
    logic [64:0] mag;
    logic [5:0] sh;
    logic rel6, uapEff, convPath, isCtrl, exRi, exCpu, exFpe, exWr, exUnp;
    logic [31:0] ctrlVal;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        return a == ADDR_INSTR || a == ADDR_SRC_LO || a == ADDR_SRC_HI
            || a == ADDR_FP_CONTROL_STATUS || a == ADDR_CONFIG || a == ADDR_FIR
            || a == ADDR_RES_LO || a == ADDR_RES_HI || a == ADDR_STATUS;
    endfunction

    // register read mux
    always_comb begin
        rdHit = isMapped(axiReq.araddr);
        wrHit = isMapped(awAddr);
        case (axiReq.araddr)
            ADDR_INSTR: rdVal = instr;
            ADDR_SRC_LO: rdVal = srcLo;
            ADDR_SRC_HI: rdVal = srcHi;
            ADDR_FP_CONTROL_STATUS: rdVal = fp_control_status;
            ADDR_CONFIG: rdVal = cfgWord;
            ADDR_FIR: rdVal = FIR_VALUE;
            ADDR_RES_LO: rdVal = resLo;
            ADDR_RES_HI: rdVal = resHi;
            ADDR_STATUS: begin
                rdVal = status;
                rdVal[ST_BUSY] = state == EX_RUN;
            end
            default: rdVal = 32'h0;
        endcase
    end

    // bus slave; address and data may arrive in either order
    always_comb begin
        next_axiRsp = axiRsp;
        next_awFull = awFull;
        next_awAddr = awAddr;
        next_wFull = wFull;
        next_wData = wData;
        next_wStrb = wStrb;
        doWrite = awFull && wFull && !axiRsp.bvalid;
        if (axiReq.awvalid && axiRsp.awready) begin
            next_awFull = 1'b1;
            next_awAddr = axiReq.awaddr;
            next_axiRsp.awready = 1'b0;
        end
        if (axiReq.wvalid && axiRsp.wready) begin
            next_wFull = 1'b1;
            next_wData = axiReq.wdata;
            next_wStrb = axiReq.wstrb;
            next_axiRsp.wready = 1'b0;
        end
        if (doWrite) begin
            next_awFull = 1'b0;
            next_wFull = 1'b0;
            next_axiRsp.bvalid = 1'b1;
            next_axiRsp.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (axiRsp.bvalid && axiReq.bready) begin
            next_axiRsp.bvalid = 1'b0;
            next_axiRsp.awready = 1'b1;
            next_axiRsp.wready = 1'b1;
        end
        if (axiReq.arvalid && axiRsp.arready) begin
            next_axiRsp.arready = 1'b0;
            next_axiRsp.rvalid = 1'b1;
            next_axiRsp.rdata = rdVal;
            next_axiRsp.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (axiRsp.rvalid && axiReq.rready) begin
            next_axiRsp.rvalid = 1'b0;
            next_axiRsp.arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            axiRsp <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
            awFull <= 1'b0;
            awAddr <= 8'h00;
            wFull <= 1'b0;
            wData <= 32'h0;
            wStrb <= 4'h0;
        end else begin
            axiRsp <= next_axiRsp;
            awFull <= next_awFull;
            awAddr <= next_awAddr;
            wFull <= next_wFull;
            wData <= next_wData;
            wStrb <= next_wStrb;
        end
    end

    // ceiling conversion datapath; sources are unpacked to a common form
    always_comb begin
        isDbl = instr[25:21] == FMT_D;
        isLong = instr[5:0] == FN_CEILING_TO_LONG;
        sgn = isDbl ? srcHi[31] : srcLo[31];
        expAll = isDbl ? srcHi[30:20] == 11'h7ff : srcLo[30:23] == 8'hff;
        expZero = isDbl ? srcHi[30:20] == 11'h000 : srcLo[30:23] == 8'h00;
        frac = isDbl ? {srcHi[19:0], srcLo} : {srcLo[22:0], 29'h0};
        ue = isDbl ? $signed({2'b00, srcHi[30:20]}) - 13'sd1023
                   : $signed({5'b00000, srcLo[30:23]}) - 13'sd127;
        mant = {11'h000, 1'b1, frac};
        isNan = expAll && frac != 52'h0;
        isInf = expAll && frac == 52'h0;
        isZero = expZero && frac == 52'h0;
        isDenorm = expZero && frac != 52'h0;
        intMag = 64'h0;
        fracNz = 1'b0;
        huge = 1'b0;
        sh = 6'h00;
        if (ue < 13'sd0) begin
            fracNz = !isZero;
        end else if (ue <= 13'sd52) begin
            sh = 6'(7'd52 - 7'(ue));
            intMag = mant >> sh;
            fracNz = (mant & ((64'h1 << sh) - 64'h1)) != 64'h0;
        end else if (ue <= 13'sd63) begin
            intMag = mant << 6'(7'(ue) - 7'd52);
        end else begin
            huge = 1'b1;
        end
        // toward plus infinity: only positive values bump up
        mag = {1'b0, intMag} + {64'h0, fracNz && !sgn};
        if (isLong) begin
            over = huge || (sgn ? mag > LONG_NEG_MAG : mag > LONG_POS_MAG);
            convVal = sgn ? 64'(-mag) : mag[63:0];
            maxVal = LONG_MAX;
            minVal = LONG_MIN;
        end else begin
            over = huge || (sgn ? mag > WORD_NEG_MAG : mag > WORD_POS_MAG);
            convVal = {32'h0, sgn ? 32'(-mag) : mag[31:0]};
            maxVal = WORD_MAX;
            minVal = WORD_MIN;
        end
        invalid = isNan || isInf || over;
        inexact = fracNz && !invalid;
        if (!fp_control_status[FP_CONTROL_STATUS_IEEE2008_NAN_MODE]) begin
            defVal = maxVal;
        end else if (isNan) begin
            defVal = 64'h0;
        end else if (sgn) begin
            defVal = minVal;
        end else begin
            defVal = maxVal;
        end
    end

    // register file and single-cycle execution
    always_comb begin
        next_state = state;
        next_instr = instr;
        next_srcLo = srcLo;
        next_srcHi = srcHi;
        next_fp_control_status = fp_control_status;
        next_cfgWord = cfgWord;
        next_status = status;
        next_resLo = resLo;
        next_resHi = resHi;
        exRi = 1'b0;
        exCpu = 1'b0;
        exFpe = 1'b0;
        exWr = 1'b0;
        exUnp = 1'b0;
        convPath = 1'b0;
        ctrlVal = 32'h0;
        rel6 = cfgWord[CFG_AR_LSB +: 3] >= AR_REL6;
        uapEff = cfgWord[CFG_UAP] && !rel6;
        isCtrl = instr[25:21] == SUB_CTRL_FROM;
        if (doWrite) begin
            case (awAddr)
                ADDR_INSTR: begin
                    // a write while busy is dropped
                    if (state == EX_IDLE) begin
                        next_instr = mergeBytes(instr, wData, wStrb);
                        next_status[ST_DONE] = 1'b0;
                        next_state = EX_RUN;
                    end
                end
                ADDR_SRC_LO: next_srcLo = mergeBytes(srcLo, wData, wStrb);
                ADDR_SRC_HI: next_srcHi = mergeBytes(srcHi, wData, wStrb);
                ADDR_FP_CONTROL_STATUS: next_fp_control_status = mergeBytes(fp_control_status, wData, wStrb);
                ADDR_CONFIG: next_cfgWord = mergeBytes(cfgWord, wData, wStrb);
                default: ;
            endcase
        end
        if (state == EX_RUN) begin
            next_state = EX_IDLE;
            if (!cfgWord[CFG_COP_EN]) begin
                exCpu = 1'b1;
            end else if (instr[31:26] != OP_FPCOP) begin
                exRi = 1'b1;
            end else if (isCtrl) begin
                if (instr[10:0] != 11'h000) begin
                    exRi = 1'b1;
                end else begin
                    case (instr[15:11])
                        CR_FIR: ctrlVal = FIR_VALUE;
                        CR_UFR: begin
                            if (uapEff) begin
                                exRi = !cfgWord[CFG_UFR_EN];
                                ctrlVal = {31'h0, cfgWord[CFG_REGMODE]};
                            end else begin
                                exRi = rel6;
                                exUnp = !rel6;
                            end
                        end
                        CR_USER_REGMODE_CLEAR_ALIAS: begin
                            exRi = rel6;
                            exUnp = !rel6;
                        end
                        CR_FRE: begin
                            exUnp = !rel6;
                            exRi = rel6 && !cfgWord[CFG_UFE_EN];
                            ctrlVal = {31'h0, cfgWord[CFG_FRE]};
                        end
                        CR_CCV: ctrlVal = {24'h0, fp_control_status[31:25], fp_control_status[23]};
                        CR_EXV: ctrlVal = {14'h0, fp_control_status[17:12], 5'h0, fp_control_status[6:2], 2'h0};
                        CR_ENV: ctrlVal = {20'h0, fp_control_status[11:7], 4'h0, fp_control_status[24], fp_control_status[1:0]};
                        CR_CSR: ctrlVal = fp_control_status;
                        default: begin
                            // includes the emulation clear alias
                            exRi = rel6;
                            exUnp = !rel6;
                        end
                    endcase
                    exWr = !exRi;
                    if (exWr) begin
                        next_resLo = ctrlVal;
                        next_resHi = 32'h0;
                    end
                end
            end else if (instr[5:0] == FN_CEILING_TO_LONG || instr[5:0] == FN_CEILING_TO_WORD) begin
                if (instr[20:16] != 5'h00
                        || (instr[25:21] != FMT_S && instr[25:21] != FMT_D)) begin
                    exRi = 1'b1;
                end else if (cfgWord[CFG_FRE] && instr[25:21] == FMT_S) begin
                    exRi = 1'b1;
                end else if (isDenorm) begin
                    // subnormals are left to software emulation
                    next_fp_control_status[17:12] = 6'h00;
                    next_fp_control_status[CAUSE_E] = 1'b1;
                    exFpe = 1'b1;
                end else begin
                    convPath = 1'b1;
                    next_fp_control_status[17:12] = 6'h00;
                    exUnp = isLong && !(cfgWord[CFG_REGMODE] && cfgWord[CFG_FPU64]);
                    if (invalid) begin
                        next_fp_control_status[FLAG_V] = 1'b1;
                        next_fp_control_status[CAUSE_V] = 1'b1;
                        exFpe = fp_control_status[EN_V];
                        exWr = !fp_control_status[EN_V];
                    end else begin
                        next_fp_control_status[FLAG_I] = fp_control_status[FLAG_I] | inexact;
                        next_fp_control_status[CAUSE_I] = inexact;
                        exFpe = inexact && fp_control_status[EN_I];
                        exWr = !exFpe;
                    end
                    if (exWr) begin
                        next_resLo = invalid ? defVal[31:0] : convVal[31:0];
                        next_resHi = invalid ? defVal[63:32] : convVal[63:32];
                    end
                end
            end else begin
                exRi = 1'b1;
            end
            next_status = 32'h0;
            next_status[ST_DONE] = 1'b1;
            next_status[ST_WROTE] = exWr;
            next_status[ST_RI] = exRi;
            next_status[ST_CPU] = exCpu;
            next_status[ST_FPE] = exFpe;
            next_status[ST_UNPRED] = exUnp;
            next_status[ST_INVALID] = convPath && invalid;
            next_status[ST_INEXACT] = convPath && inexact;
            next_status[ST_DEST_LSB +: 5] = isCtrl ? instr[20:16] : instr[10:6];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= EX_IDLE;
            instr <= 32'h0;
            srcLo <= 32'h0;
            srcHi <= 32'h0;
            fp_control_status <= FP_CONTROL_STATUS_RESET;
            cfgWord <= CONFIG_RESET;
            status <= 32'h0;
            resLo <= 32'h0;
            resHi <= 32'h0;
        end else begin
            state <= next_state;
            instr <= next_instr;
            srcLo <= next_srcLo;
            srcHi <= next_srcHi;
            fp_control_status <= next_fp_control_status;
            cfgWord <= next_cfgWord;
            status <= next_status;
            resLo <= next_resLo;
            resHi <= next_resHi;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    ceil_long_a: assert property (
        state == EX_RUN && convPath && isLong && !invalid && !exFpe
        |=> {resHi, resLo} == $past(convVal) && status[ST_WROTE])
        else $error("long conversion result wrong");
    ceil_word_a: assert property (
        state == EX_RUN && convPath && !isLong && !invalid && !exFpe
        |=> resLo == $past(convVal[31:0]) && resHi == 32'h0)
        else $error("word conversion result wrong");
    inval_flag_a: assert property (
        state == EX_RUN && convPath && invalid
        |=> fp_control_status[FLAG_V] && fp_control_status[CAUSE_V] && status[ST_INVALID])
        else $error("invalid flag not raised");
    trap_nowrite_a: assert property (
        state == EX_RUN && convPath && invalid && fp_control_status[EN_V]
        |=> status[ST_FPE] && !status[ST_WROTE] && $stable(resLo) && $stable(resHi))
        else $error("invalid trap wrote a result");
    legacy_default_a: assert property (
        state == EX_RUN && convPath && invalid && !fp_control_status[EN_V] && !fp_control_status[FP_CONTROL_STATUS_IEEE2008_NAN_MODE]
        |=> {resHi, resLo} == $past(maxVal))
        else $error("legacy default not maximum");
    nan_zero_a: assert property (
        state == EX_RUN && convPath && isNan && !fp_control_status[EN_V] && fp_control_status[FP_CONTROL_STATUS_IEEE2008_NAN_MODE]
        |=> resLo == 32'h0 && resHi == 32'h0)
        else $error("NaN default not zero");
    neg_bound_a: assert property (
        state == EX_RUN && convPath && invalid && !isNan && sgn
        && !fp_control_status[EN_V] && fp_control_status[FP_CONTROL_STATUS_IEEE2008_NAN_MODE]
        |=> {resHi, resLo} == $past(minVal))
        else $error("negative default wrong");
    ccv_view_a: assert property (
        state == EX_RUN && cfgWord[CFG_COP_EN] && instr[31:26] == OP_FPCOP && isCtrl
        && instr[10:0] == 11'h000 && instr[15:11] == CR_CCV
        |=> resLo == {24'h0, $past(fp_control_status[31:25]), $past(fp_control_status[23])} && status[ST_WROTE])
        else $error("condition code view wrong");
    missing_reg_a: assert property (
        state == EX_RUN && cfgWord[CFG_COP_EN] && instr[31:26] == OP_FPCOP && isCtrl
        && instr[10:0] == 11'h000 && rel6 && instr[15:11] == 5'h03
        |=> status[ST_RI] && !status[ST_WROTE])
        else $error("missing control register did not trap");
    fre_single_a: assert property (
        state == EX_RUN && cfgWord[CFG_COP_EN] && !isCtrl && instr[31:26] == OP_FPCOP
        && cfgWord[CFG_FRE] && instr[25:21] == FMT_S && instr[20:16] == 5'h00
        && (instr[5:0] == FN_CEILING_TO_LONG || instr[5:0] == FN_CEILING_TO_WORD)
        |=> status[ST_RI] && $stable(resLo))
        else $error("emulation enable did not trap single");
endmodule
`default_nettype wire

// *** pkg/fcc_pkg.sv ***
package fcc_pkg;
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_SRC_LO = 8'h04;
    localparam logic [7:0] ADDR_SRC_HI = 8'h08;
    localparam logic [7:0] ADDR_FP_CONTROL_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_FIR = 8'h14;
    localparam logic [7:0] ADDR_RES_LO = 8'h18;
    localparam logic [7:0] ADDR_RES_HI = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [31:0] FP_CONTROL_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0207;
    localparam int CFG_COP_EN = 0;
    localparam int CFG_REGMODE = 1;
    localparam int CFG_FPU64 = 2;
    localparam int CFG_UAP = 3;
    localparam int CFG_UFR_EN = 4;
    localparam int CFG_UFE_EN = 5;
    localparam int CFG_FRE = 6;
    localparam int CFG_AR_LSB = 8;
    localparam logic [2:0] AR_REL6 = 3'h2;
    localparam int ST_DONE = 0;
    localparam int ST_WROTE = 1;
    localparam int ST_RI = 2;
    localparam int ST_CPU = 3;
    localparam int ST_FPE = 4;
    localparam int ST_UNPRED = 5;
    localparam int ST_INVALID = 6;
    localparam int ST_INEXACT = 7;
    localparam int ST_DEST_LSB = 8;
    localparam int ST_BUSY = 15;
    localparam int FP_CONTROL_STATUS_IEEE2008_NAN_MODE = 18;
    localparam int CAUSE_E = 17;
    localparam int CAUSE_V = 16;
    localparam int CAUSE_I = 12;
    localparam int EN_V = 11;
    localparam int EN_I = 7;
    localparam int FLAG_V = 6;
    localparam int FLAG_I = 2;
    localparam logic [5:0] OP_FPCOP = 6'h11;
    localparam logic [5:0] FN_CEILING_TO_LONG = 6'h0a;
    localparam logic [5:0] FN_CEILING_TO_WORD = 6'h0e;
    localparam logic [4:0] SUB_CTRL_FROM = 5'h02;
    localparam logic [4:0] FMT_S = 5'h10;
    localparam logic [4:0] FMT_D = 5'h11;
    localparam logic [4:0] CR_FIR = 5'h00;
    localparam logic [4:0] CR_UFR = 5'h01;
    localparam logic [4:0] CR_USER_REGMODE_CLEAR_ALIAS = 5'h04;
    localparam logic [4:0] CR_FRE = 5'h05;
    localparam logic [4:0] CR_CCV = 5'h19;
    localparam logic [4:0] CR_EXV = 5'h1a;
    localparam logic [4:0] CR_ENV = 5'h1c;
    localparam logic [4:0] CR_CSR = 5'h1f;
    localparam logic [64:0] LONG_POS_MAG = 65'h0_7fff_ffff_ffff_ffff;
    localparam logic [64:0] LONG_NEG_MAG = 65'h0_8000_0000_0000_0000;
    localparam logic [64:0] WORD_POS_MAG = 65'h0_0000_0000_7fff_ffff;
    localparam logic [64:0] WORD_NEG_MAG = 65'h0_0000_0000_8000_0000;
    localparam logic [63:0] LONG_MAX = 64'h7fff_ffff_ffff_ffff;
    localparam logic [63:0] LONG_MIN = 64'h8000_0000_0000_0000;
    localparam logic [63:0] WORD_MAX = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] WORD_MIN = 64'h0000_0000_8000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        EX_IDLE = 1'b0,
        EX_RUN = 1'b1
    } fcc_exec_state_type;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } fcc_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fcc_axil_rsp_type;
endpackage

// *** sim/fcc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_core_model (
    input wire logic clk_sys,
    input wire fcc_pkg::fcc_axil_rsp_type axiRsp,
    output var fcc_pkg::fcc_axil_req_type axiReq
);
    import fcc_pkg::*;
    initial axiReq = '0;
    // each channel holds until its own handshake; no cycle count assumed
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic fin;
        fin = 1'b0;
        @(posedge clk_sys);
        axiReq.awaddr <= addr;
        axiReq.wdata <= data;
        axiReq.wstrb <= 4'hf;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        while (!fin) begin
            @(posedge clk_sys);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid) begin
                axiReq.bready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] addr);
        logic fin;
        fin = 1'b0;
        @(posedge clk_sys);
        axiReq.araddr <= addr;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        while (!fin) begin
            @(posedge clk_sys);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid) begin
                axiReq.rready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// *** sim/fcc_fpu_slice_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_fpu_slice_tb_top;
    import fcc_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] m;
        logic [33:0] e;
    } fcc_note_type;
    // arbitrary value, not tied to any part
    localparam logic [31:0] FIR_V = 32'h0000_5a01;
    localparam logic [31:0] M = 32'hffff_ffff;
    localparam logic [31:0] C = CONFIG_RESET;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    fcc_axil_req_type req;
    fcc_axil_rsp_type rsp;
    fcc_note_type notes[$];
    fcc_note_type nt;
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] rnd = 32'h0001_1c68;
    logic [31:0] f;
    always #5 clk_sys = ~clk_sys;
    fcc_fpu_slice #(.FIR_VALUE(FIR_V)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .axiReq(req), .axiRsp(rsp));
    fcc_core_model core_u (.clk_sys(clk_sys), .axiRsp(rsp), .axiReq(req));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] cv(input logic [5:0] fn, input logic [4:0] fmt);
        return {OP_FPCOP, fmt, 5'h00, 5'h02, 5'h03, fn};
    endfunction
    function automatic logic [31:0] cf(input logic [4:0] cr);
        return {OP_FPCOP, SUB_CTRL_FROM, 5'h04, cr, 11'h000};
    endfunction
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
        notes.push_back('{a, m, e});
        core_u.rd(a);
    endtask
    // full setup every time so no earlier case leaks into the next
    task automatic run(input logic [31:0] cfg, fc, hi, lo, ins, input logic [7:0] a,
        input logic [31:0] m, e);
        core_u.wr(ADDR_CONFIG, cfg);
        core_u.wr(ADDR_FP_CONTROL_STATUS, fc);
        core_u.wr(ADDR_SRC_HI, hi);
        core_u.wr(ADDR_SRC_LO, lo);
        core_u.wr(ADDR_INSTR, ins);
        rdx(a, m, {RESP_OKAY, e});
    endtask
    always @(posedge clk_sys) begin
        if (rsp.rvalid && req.rready) begin
            nt = notes.pop_front();
            chk($sformatf("read %h", nt.a), {rsp.rresp, rsp.rdata & nt.m}, nt.e);
        end
        // every bench write goes to a mapped register
        if (rsp.bvalid && req.bready) begin
            chk("write response", 34'(rsp.bresp), 34'(RESP_OKAY));
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdx(ADDR_CONFIG, M, {RESP_OKAY, CONFIG_RESET});
        rdx(ADDR_FP_CONTROL_STATUS, M, {RESP_OKAY, FP_CONTROL_STATUS_RESET});
        rdx(ADDR_FIR, M, {RESP_OKAY, FIR_V});
        rdx(8'h24, M, {RESP_SLVERR, 32'h0000_0000});
        run(C, 0, 0, 32'h3fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_RES_LO, M, 2);
        run(C, 0, 0, 32'hbfc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_RES_LO, M, M);
        run(C, 0, 32'h41f0_0000, 32'h0008_0000, cv(FN_CEILING_TO_LONG, FMT_D), ADDR_RES_HI, M, 1);
        rdx(ADDR_RES_LO, M, {RESP_OKAY, 32'h0000_0001});
        run(C, 0, 0, 32'h7fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_RES_LO, M, WORD_MAX[31:0]);
        rdx(ADDR_FP_CONTROL_STATUS, 32'h0001_0040, {RESP_OKAY, 32'h0001_0040});
        run(C, 32'h0004_0000, 0, 32'h7fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_RES_LO, M, 0);
        run(C, 32'h0004_0000, 32'h7ff0_0000, 0, cv(FN_CEILING_TO_LONG, FMT_D), ADDR_RES_HI, M,
            LONG_MAX[63:32]);
        rdx(ADDR_RES_LO, M, {RESP_OKAY, LONG_MAX[31:0]});
        run(C, 32'h0004_0000, 0, 32'hff80_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_RES_LO, M,
            WORD_MIN[31:0]);
        run(C, 32'h0000_0800, 0, 32'h7fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_STATUS, 32'h12,
            32'h10);
        run(C, 0, 0, 32'h3fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_FP_CONTROL_STATUS, 32'h1004, 32'h1004);
        run(32'h205, 0, 32'h4004_0000, 0, cv(FN_CEILING_TO_LONG, FMT_D), ADDR_STATUS, 32'h20,
            32'h20);
        run(32'h206, 0, 0, 32'h3fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_STATUS, 8, 8);
        run(32'h247, 0, 0, 32'h3fc0_0000, cv(FN_CEILING_TO_WORD, FMT_S), ADDR_STATUS, 4, 4);
        run(C, 0, 0, 0, cf(CR_UFR), ADDR_STATUS, 4, 4);
        run(C, 0, 0, 0, cf(CR_USER_REGMODE_CLEAR_ALIAS), ADDR_STATUS, 4, 4);
        run(C, 0, 0, 0, cf(5'h03), ADDR_STATUS, 4, 4);
        run(32'h07, 0, 0, 0, cf(5'h03), ADDR_STATUS, 32'h26, 32'h22);
        run(32'h1f, 0, 0, 0, cf(CR_UFR), ADDR_RES_LO, M, 1);
        run(32'h0f, 0, 0, 0, cf(CR_UFR), ADDR_STATUS, 4, 4);
        run(C, 0, 0, 0, cf(CR_FRE), ADDR_STATUS, 4, 4);
        run(32'h267, 0, 0, 0, cf(CR_FRE), ADDR_RES_LO, M, 1);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            f = rnd;
            run(C, f, 0, 0, cf(CR_CCV), ADDR_RES_LO, M, {24'h0, f[31:25], f[23]});
            run(C, f, 0, 0, cf(CR_EXV), ADDR_RES_LO, M,
                {14'h0, f[17:12], 5'h0, f[6:2], 2'h0});
            run(C, f, 0, 0, cf(CR_ENV), ADDR_RES_LO, M,
                {20'h0, f[11:7], 4'h0, f[24], f[1:0]});
            // bits 22..19 left out: implementation-owned in the status word
            run(C, f, 0, 0, cf(CR_CSR), ADDR_RES_LO, 32'hff87_ffff, f & 32'hff87_ffff);
            run(C, f, 0, 0, cf(CR_FIR), ADDR_RES_LO, M, FIR_V);
        end
        @(posedge clk_sys);
        give_verdict();
    end
endmodule
`default_nettype wire
